// *** hdl/twsmp_pkg.sv ***
// two-wire slave memory port: shared constants, types and helpers
// assumes a 40 MHz system clock; the line monitor, array and top modules import this package
`default_nettype none

package twsmp_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_KHZ     = 40000;
    localparam int NV_WRITE_TIME_US = 5000;
    localparam int NV_WRITE_CYCLES_DEF =
        (NV_WRITE_TIME_US * CLK_FREQ_KHZ + 999) / 1000;

    // ------------------------------------------------------------
    // memory map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_FIRST = 8'h80;
    localparam logic [7:0] ADDR_LAST       = 8'hCF;
    localparam logic [7:0] ADDR_CTL0       = 8'h80;
    localparam logic [7:0] ADDR_CTL5       = 8'h85;
    localparam logic [7:0] ADDR_LATCH      = 8'h86;
    localparam logic [7:0] LATCH_SET_BYTE  = 8'h80;
    localparam logic [7:0] LATCH_CLR_BYTE  = 8'h00;
    localparam logic [7:0] TABLE_RESET     = 8'h00;
    localparam logic [7:0] UNMAPPED_BYTE   = 8'h00;
    localparam int         MEM_BYTES       = 80;
    localparam int         PAGE_BYTES      = 16;
    localparam int         IDX_W           = 7;
    localparam int         BYTE_W          = 4;
    localparam int         PAGE_W          = 3;
    localparam logic [2:0] CTRL_PAGE       = 3'h0;

    // ------------------------------------------------------------
    // bus framing
    // ------------------------------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] FIRST_BIT     = 4'h1;
    localparam int         STRAP_W       = 3;
    localparam logic       LINE_IDLE     = 1'b1;

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK}
        twsmp_state_t;
    typedef enum logic [1:0] {PH_SLAVE, PH_MADDR, PH_DATA} twsmp_phase_t;

    // true for a location inside the 80-byte array
    function automatic logic addr_in_map(input logic [7:0] a);
        return (a >= ADDR_CTRL_FIRST) && (a <= ADDR_LAST);
    endfunction

    // byte location to array index
    function automatic logic [IDX_W-1:0] addr_to_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - ADDR_CTRL_FIRST;
        return d[IDX_W-1:0];
    endfunction

endpackage

`default_nettype wire

// *** hdl/twsmp_if.sv ***
// carriers between the port core, its line monitor and its array
// assumes all three modules sit on the same clock
`default_nettype none

// conditioned bus events from the line monitor
interface twsmp_line_if;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    modport mon  (output sda, scl_rise, scl_fall, start, stop);
    modport core (input  sda, scl_rise, scl_fall, start, stop);
endinterface

// array access: read by index, page load, commit
interface twsmp_mem_if;
    logic [6:0] rd_idx;
    logic [7:0] rd_data;
    logic       ld_en;
    logic [6:0] ld_idx;
    logic [7:0] ld_data;
    logic       commit;
    logic       discard;
    logic       pend_nv;
    modport store (input  rd_idx, ld_en, ld_idx, ld_data, commit, discard,
                   output rd_data, pend_nv);
    modport core  (output rd_idx, ld_en, ld_idx, ld_data, commit, discard,
                   input  rd_data, pend_nv);
endinterface

`default_nettype wire

// *** hdl/twsmp_line_mon.sv ***
// line monitor: synchronises SCL and SDA, finds edges, START and STOP
// assumes the pins are asynchronous to clk and idle high
`default_nettype none

module twsmp_line_mon (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic scl_pin,
    input  wire logic sda_pin,
    twsmp_line_if.mon lif
);
    import twsmp_pkg::*;

    logic scl_s1_r;
    logic scl_s2_r;
    logic scl_s3_r;
    logic sda_s1_r;
    logic sda_s2_r;
    logic sda_s3_r;

    // two-stage sync plus one history stage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            scl_s1_r <= LINE_IDLE;
            scl_s2_r <= LINE_IDLE;
            scl_s3_r <= LINE_IDLE;
            sda_s1_r <= LINE_IDLE;
            sda_s2_r <= LINE_IDLE;
            sda_s3_r <= LINE_IDLE;
        end else begin
            scl_s1_r <= scl_pin;
            scl_s2_r <= scl_s1_r;
            scl_s3_r <= scl_s2_r;
            sda_s1_r <= sda_pin;
            sda_s2_r <= sda_s1_r;
            sda_s3_r <= sda_s2_r;
        end
    end

    // events only from the second and third stages
    assign lif.sda      = sda_s2_r;
    assign lif.scl_rise = scl_s2_r & ~scl_s3_r;
    assign lif.scl_fall = ~scl_s2_r & scl_s3_r;
    assign lif.start    = scl_s2_r & scl_s3_r & ~sda_s2_r & sda_s3_r;
    assign lif.stop     = scl_s2_r & scl_s3_r & sda_s2_r & ~sda_s3_r;

endmodule

`default_nettype wire

// *** hdl/twsmp_mem.sv ***
// 80-byte array with a one-page load buffer committed on request
// assumes loads of one transfer stay inside one 16-byte page
`default_nettype none

module twsmp_mem (
    input  wire logic  clk,
    input  wire logic  rstn,
    twsmp_mem_if.store mif
);
    import twsmp_pkg::*;

    logic [7:0]            mem_r  [MEM_BYTES];
    logic [7:0]            buf_r  [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask_r;
    logic [PAGE_W-1:0]     page_r;

    // array cleared; later load overwrites buffered byte
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
                mem_r[i] <= TABLE_RESET;
            end
        end else if (mif.commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (mask_r[i]) begin
                    mem_r[{page_r, BYTE_W'(i)}] <= buf_r[i];
                end
            end
        end
    end

    // load buffer data
    always_ff @(posedge clk) begin
        if (mif.ld_en) begin
            buf_r[mif.ld_idx[BYTE_W-1:0]] <= mif.ld_data;
        end
    end

    // page of pending bytes and which bytes are loaded
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mask_r <= '0;
            page_r <= CTRL_PAGE;
        end else if (mif.commit || mif.discard) begin
            mask_r <= '0;
        end else if (mif.ld_en) begin
            mask_r[mif.ld_idx[BYTE_W-1:0]] <= 1'b1;
            page_r <= mif.ld_idx[IDX_W-1:BYTE_W];
        end
    end

    // read port and nonvolatile pending flag
    assign mif.rd_data = (int'(mif.rd_idx) < MEM_BYTES) ?
                         mem_r[mif.rd_idx] : UNMAPPED_BYTE;
    assign mif.pend_nv = (|mask_r) && (page_r != CTRL_PAGE);

endmodule

`default_nettype wire

// *** hdl/twsmp_top.sv ***
// two-wire slave memory port: bit engine, acknowledge policy, pointer,
// write enable latch and nonvolatile write timer
// assumes an external open-drain SDA driver and pull-ups on SCL and SDA
`default_nettype none

// How it works
// - after eight bits the sender releases SDA; receiver pulls low on ninth
// - slave address acknowledged only if top four bits match type id
// - next three address bits must equal the address strap pins
// - last slave address bit: one reads, zero writes
// - in write mode each following byte is acknowledged unless excepted
// - read: send eight bits, sample acknowledge, continue only when low
// - data refused while latch clear, except 86h; none after 80h/85h/86h
// - control page at 80h-8Fh, lookup table at 90h-CFh
// - lookup table holds zero before any programming
// - every byte shifted most significant bit first
// - memory is five pages of sixteen bytes; pages bound write wrapping
// - nonvolatile write lasts 5 ms; all commands ignored meanwhile
// - polling: slave address refused while busy, acknowledged after
// - byte write: address, location, one data byte, STOP; volatile ready
// - during nonvolatile write SDA is never driven
// - page write to any lookup page, acknowledging and advancing per byte
// - page bits fixed; byte counter wraps from page end to page start
// - bytes beyond sixteen overwrite the wrapped location
// - STOP after page loading starts the write; inputs disabled meanwhile
// - latch clear at reset; 80h at 86h sets it, 00h clears it
// - write protect low refuses every write except the latch write
module twsmp_top #(
    parameter logic [3:0] TYPE_ID         = 4'h5, // arbitrary value
    parameter int         NV_WRITE_CYCLES = twsmp_pkg::NV_WRITE_CYCLES_DEF
) (
    input  wire logic                        CLK,
    input  wire logic                        RSTN,
    input  wire logic                        SCL_IN,
    input  wire logic                        SDA_IN,
    output var  logic                        SDA_OUT,
    output var  logic                        SDA_OE,
    input  wire logic [twsmp_pkg::STRAP_W-1:0] ADDRESS_STRAP_PINS,
    input  wire logic                        WRITE_PROTECT_N,
    output var  logic                        WRITE_ENABLE_LATCH,
    output var  logic                        NV_WRITE_BUSY
);
    import twsmp_pkg::*;

    localparam int BUSY_W = $clog2(NV_WRITE_CYCLES + 1);

    // ------------------------------------------------------------
    // line monitor and array
    // ------------------------------------------------------------
    twsmp_line_if lif ();
    twsmp_mem_if  mif ();

    twsmp_line_mon u_mon (
        .clk     (CLK),
        .rstn    (RSTN),
        .scl_pin (SCL_IN),
        .sda_pin (SDA_IN),
        .lif     (lif)
    );

    twsmp_mem u_mem (
        .clk  (CLK),
        .rstn (RSTN),
        .mif  (mif)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    twsmp_state_t       st_r;
    twsmp_phase_t       phase_r;
    logic [3:0]         cnt_r;
    logic [7:0]         shift_r;
    logic [7:0]         ptr_r;
    logic               rack_r;
    logic               block_r;
    logic               latch_r;
    logic               busy_r;
    logic [BUSY_W-1:0]  busy_cnt_r;
    logic [STRAP_W-1:0] strap_s1_r;
    logic [STRAP_W-1:0] strap_s2_r;
    logic               wp_s1_r;
    logic               wp_s2_r;

    logic       byte_done;
    logic       slave_ok;
    logic       data_ok;
    logic       ack_now;
    logic       ptr_is_latch;
    logic       ptr_blocks;
    logic       ack_fall;
    logic       load_rd;
    logic       latch_write;
    logic       nv_start;
    logic [7:0] tx_byte;
    logic [3:0] ptr_page;

    // strap and write protect pins synchronised
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            strap_s1_r <= '0;
            strap_s2_r <= '0;
            wp_s1_r    <= 1'b0;
            wp_s2_r    <= 1'b0;
        end else begin
            strap_s1_r <= ADDRESS_STRAP_PINS;
            strap_s2_r <= strap_s1_r;
            wp_s1_r    <= WRITE_PROTECT_N;
            wp_s2_r    <= wp_s1_r;
        end
    end

    // ------------------------------------------------------------
    // acknowledge policy
    // ------------------------------------------------------------
    assign byte_done  = (st_r == ST_RX) && (cnt_r == BITS_PER_BYTE)
                        && lif.scl_fall;
    assign ptr_is_latch = (ptr_r == ADDR_LATCH);
    assign ptr_page     = ptr_r[7:4];
    assign ptr_blocks   = (ptr_r == ADDR_CTL0) || (ptr_r == ADDR_CTL5)
                          || ptr_is_latch;
    // type id, strap match, silent while busy
    assign slave_ok     = (shift_r[7:4] == TYPE_ID)
                          && (shift_r[3:1] == strap_s2_r) && !busy_r;
    // latch, protect pin, follow-on and map checks
    assign data_ok      = addr_in_map(ptr_r) && !block_r
                          && (ptr_is_latch || (latch_r && wp_s2_r));
    // location byte always taken, data per policy
    always_comb begin
        unique case (phase_r)
            PH_SLAVE: ack_now = slave_ok;
            PH_MADDR: ack_now = 1'b1;
            PH_DATA:  ack_now = data_ok;
            default:  ack_now = 1'b0;
        endcase
    end

    assign ack_fall  = (st_r == ST_ACK) && lif.scl_fall;
    // read selected by the direction bit
    assign load_rd   = lif.scl_fall
                       && (((st_r == ST_ACK) && (phase_r == PH_SLAVE)
                            && shift_r[0])
                           || ((st_r == ST_RACK) && rack_r));
    assign latch_write = byte_done && (phase_r == PH_DATA) && ack_now
                         && ptr_is_latch;
    assign tx_byte   = ptr_is_latch ? {latch_r, 7'h00} :
                       addr_in_map(ptr_r) ? mif.rd_data : UNMAPPED_BYTE;

    // ------------------------------------------------------------
    // bit engine
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            st_r    <= ST_IDLE;
            phase_r <= PH_SLAVE;
            cnt_r   <= '0;
            shift_r <= '0;
            rack_r  <= 1'b0;
            SDA_OE  <= 1'b0;
        end else if (lif.start) begin
            st_r    <= ST_RX;
            phase_r <= PH_SLAVE;
            cnt_r   <= '0;
            SDA_OE  <= 1'b0;
        end else if (lif.stop) begin
            st_r   <= ST_IDLE;
            SDA_OE <= 1'b0;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    cnt_r <= '0;
                end
                ST_RX: begin
                    if (lif.scl_rise && (cnt_r != BITS_PER_BYTE)) begin
                        shift_r <= {shift_r[6:0], lif.sda};
                        cnt_r   <= cnt_r + FIRST_BIT;
                    end else if (byte_done) begin
                        // pull low through the ninth clock
                        st_r   <= ack_now ? ST_ACK : ST_IDLE;
                        SDA_OE <= ack_now;
                    end
                end
                ST_ACK: begin
                    if (load_rd) begin
                        st_r    <= ST_TX;
                        shift_r <= tx_byte;
                        SDA_OE  <= ~tx_byte[7];
                        cnt_r   <= FIRST_BIT;
                    end else if (lif.scl_fall) begin
                        st_r    <= ST_RX;
                        SDA_OE  <= 1'b0;
                        cnt_r   <= '0;
                        phase_r <= (phase_r == PH_SLAVE) ? PH_MADDR
                                                         : PH_DATA;
                    end
                end
                ST_TX: begin
                    if (lif.scl_fall) begin
                        if (cnt_r == BITS_PER_BYTE) begin
                            st_r   <= ST_RACK;
                            SDA_OE <= 1'b0;
                        end else begin
                            SDA_OE  <= ~shift_r[6];
                            shift_r <= {shift_r[6:0], 1'b0};
                            cnt_r   <= cnt_r + FIRST_BIT;
                        end
                    end
                end
                // continue on low acknowledge, else stop sending
                ST_RACK: begin
                    if (lif.scl_rise) begin
                        rack_r <= ~lif.sda;
                    end else if (load_rd) begin
                        st_r    <= ST_TX;
                        shift_r <= tx_byte;
                        SDA_OE  <= ~tx_byte[7];
                        cnt_r   <= FIRST_BIT;
                    end else if (lif.scl_fall) begin
                        st_r <= ST_IDLE;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ptr_r <= ADDR_CTRL_FIRST;
        end else if (load_rd) begin
            ptr_r <= ptr_r + 8'h01;
        end else if (ack_fall && (phase_r == PH_MADDR)) begin
            ptr_r <= shift_r;
        end else if (ack_fall && (phase_r == PH_DATA)) begin
            ptr_r <= {ptr_r[7:4], ptr_r[3:0] + 4'h1};
        end
    end

    // refuse every data byte after one at 80h, 85h or 86h
    always_ff @(posedge CLK) begin
        if (!RSTN || lif.start) begin
            block_r <= 1'b0;
        end else if (byte_done && (phase_r == PH_DATA) && ptr_blocks) begin
            block_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            latch_r <= 1'b0;
        end else if (latch_write && (shift_r == LATCH_SET_BYTE)) begin
            latch_r <= 1'b1;
        end else if (latch_write && (shift_r == LATCH_CLR_BYTE)) begin
            latch_r <= 1'b0;
        end
    end

    // commit only at a byte boundary STOP
    assign mif.rd_idx  = addr_to_idx(ptr_r);
    assign mif.ld_idx  = addr_to_idx(ptr_r);
    assign mif.ld_data = shift_r;
    assign mif.ld_en   = byte_done && (phase_r == PH_DATA) && ack_now
                         && !ptr_is_latch;
    assign mif.commit  = lif.stop && (st_r == ST_RX)
                         && (cnt_r == FIRST_BIT) // stop's own scl rise
                         && (phase_r == PH_DATA);
    assign mif.discard = lif.start || lif.stop;
    assign nv_start    = mif.commit && mif.pend_nv;

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            busy_r     <= 1'b0;
            busy_cnt_r <= '0;
        end else if (nv_start) begin
            busy_r     <= 1'b1;
            busy_cnt_r <= BUSY_W'(NV_WRITE_CYCLES - 1);
        end else if (busy_r) begin
            busy_r     <= (busy_cnt_r != '0);
            busy_cnt_r <= busy_cnt_r - BUSY_W'(1);
        end
    end

    // open-drain low level and status outputs
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            SDA_OUT            <= 1'b0;
            WRITE_ENABLE_LATCH <= 1'b0;
            NV_WRITE_BUSY      <= 1'b0;
        end else begin
            SDA_OUT            <= 1'b0;
            WRITE_ENABLE_LATCH <= latch_r;
            NV_WRITE_BUSY      <= busy_r;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    chk_ack_drive: assert property (
        (st_r == ST_ACK) |-> SDA_OE) else $error("ack not driven low");
    chk_slave_match: assert property (
        (st_r == ST_ACK) && (phase_r == PH_SLAVE) |->
        (shift_r[7:4] == TYPE_ID) && (shift_r[3:1] == strap_s2_r))
        else $error("ack for foreign slave address");
    chk_busy_silent: assert property (
        busy_r |=> !SDA_OE) else $error("SDA driven while busy");
    chk_poll_refused: assert property (
        busy_r && byte_done && (phase_r == PH_SLAVE) |=> (st_r == ST_IDLE))
        else $error("poll acknowledged while busy");
    chk_busy_hold: assert property (
        $rose(busy_r) |-> busy_r [*8]) else $error("write cycle too short");
    chk_latch_cause: assert property (
        $rose(latch_r) |-> $past(ptr_is_latch))
        else $error("latch set elsewhere");
    chk_load_gate: assert property (
        mif.ld_en |-> latch_r && wp_s2_r && !block_r)
        else $error("data loaded while refused");
    chk_page_fixed: assert property (
        ack_fall && (phase_r == PH_DATA) |=> (ptr_page == $past(ptr_page)))
        else $error("page bits moved in write");
    chk_tx_release: assert property (
        (st_r == ST_RACK) |-> !SDA_OE) else $error("SDA held in ack slot");

    cov_byte_commit: cover property (mif.commit && !mif.pend_nv);
    cov_nv_write:    cover property (nv_start);
    cov_read_more:   cover property ((st_r == ST_RACK) && load_rd);
    cov_poll_busy:   cover property (busy_r && lif.start);

endmodule

`default_nettype wire

// *** bench/twsmp_master.sv ***
// bus master model: drives SCL and SDA, one bit per 8 clocks (200 ns)
// assumes a pulled-up, wired-and SDA resolved by the bench
`default_nettype none

module twsmp_master (
    input  wire logic clk,
    output var  logic scl,
    output var  logic sda_m,
    input  wire logic sda_line
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus, both lines released high
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // quarter-bit step of two clocks, moves on falling edges only
    task automatic q(input int n);
        repeat (2 * n) @(negedge clk);
    endtask

    // one bit: data set mid-low, line sampled at the end of high
    task automatic bit_io(input logic b, output logic r);
        q(1);
        sda_m = b;
        q(1);
        scl = 1'b1;
        q(2);
        r = sda_line;
        scl = 1'b0;
    endtask

    // start or repeated start
    task automatic start();
        q(1);
        sda_m = 1'b1;
        q(1);
        scl = 1'b1;
        q(1);
        sda_m = 1'b0;
        q(1);
        scl = 1'b0;
    endtask

    task automatic stop();
        q(1);
        sda_m = 1'b0;
        q(1);
        scl = 1'b1;
        q(1);
        sda_m = 1'b1;
        q(1);
    endtask

    // eight bits msb first, then the ninth with a
    task automatic byte_io(input logic [7:0] tx, input logic a,
                           output logic [7:0] rx, output logic n);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(a, n);
    endtask
endmodule

`default_nettype wire

// *** bench/twsmp_tb_top.sv ***
// testbench top: port under test, bus master model and scenarios
// assumes twsmp_top, twsmp_master and twsmp_pkg compiled before
`default_nettype none

module twsmp_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] TID = 4'h5; // arbitrary value
    localparam logic [2:0] STP = 3'h5;
    localparam logic [7:0] SA  = {TID, STP, 1'b0};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wp_n = 1'b1;
    logic oe, so, latch, busy, scl, sda_m;
    logic [7:0] q[$];
    logic [7:0] na;
    logic a;
    wire logic sda;
    int n_errors = 0;
    int checks_done = 0;

    assign sda = sda_m & ~(oe & ~so);
    // 40 MHz clock
    always #12.5 clk = ~clk;

    // write cycle long enough for a poll to land inside it
    twsmp_top #(.TYPE_ID(TID), .NV_WRITE_CYCLES(200)) i_dut (
        .CLK(clk), .RSTN(rstn), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(so), .SDA_OE(oe), .ADDRESS_STRAP_PINS(STP),
        .WRITE_PROTECT_N(wp_n), .WRITE_ENABLE_LATCH(latch),
        .NV_WRITE_BUSY(busy));
    twsmp_master i_m (.clk(clk), .scl(scl), .sda_m(sda_m),
        .sda_line(sda));

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one written byte, returns 1 when acknowledged
    task automatic tx(input logic [7:0] b, output logic ack);
        logic [7:0] r;
        logic n;
        i_m.byte_io(b, 1'b1, r, n);
        ack = ~n;
    endtask

    // write transfer to used locations, counts acked bytes
    task automatic wseq(input logic [7:0] loc, input logic [7:0] d[$],
                        output logic [7:0] n);
        logic k;
        i_m.start();
        tx(SA, k);
        n = 8'(k);
        tx(loc, k);
        n = n + 8'(k);
        foreach (d[i]) begin
            tx(d[i], k);
            n = n + 8'(k);
        end
        i_m.stop();
    endtask

    // read of n bytes from loc, last one not acknowledged
    task automatic rseq(input logic [7:0] loc, input int n);
        logic k;
        logic [7:0] d;
        q = {};
        i_m.start();
        tx(SA, k);
        tx(loc, k);
        i_m.start();
        tx(SA | 8'h01, k);
        for (int i = 0; i < n; i++) begin
            i_m.byte_io(8'hFF, i == n - 1, d, k);
            q.push_back(d);
        end
        i_m.stop();
    endtask

    // bounded wait for the write cycle to end
    task automatic wait_idle();
        repeat (4) @(negedge clk);
        for (int i = 0; i < 1000 && busy !== 1'b0; i++)
            @(negedge clk);
        if (busy !== 1'b0) begin
            n_errors++;
            $display("MISMATCH t=%0t write cycle never ended", $time);
            finish_test();
        end
    endtask

    task automatic t_addr();
        i_m.start();
        tx({~TID, STP, 1'b0}, a);
        chk(8'(a), 8'h00);
        i_m.start();
        tx({TID, ~STP, 1'b1}, a);
        chk(8'(a), 8'h00);
        i_m.stop();
        rseq(8'h90, 2);
        chk(q[0] | q[1], 8'h00);
        $display("addressing done");
    endtask

    task automatic t_latch();
        chk(8'({oe, latch, busy}), 8'h00);
        wseq(8'h95, '{8'h5A}, na);
        chk(na, 8'h02);
        wseq(8'h86, '{8'h80}, na);
        chk({na[6:0], latch}, 8'h07);
        wseq(8'h95, '{8'hA5}, na);
        chk(na, 8'h03);
        i_m.start();
        tx(SA, a);
        i_m.stop();
        chk(8'({a, busy}), 8'h01);
        wait_idle();
        rseq(8'h95, 1);
        chk(q[0], 8'hA5);
        $display("byte write done");
    endtask

    task automatic t_page();
        logic [7:0] d[$];
        logic [7:0] e[16];
        for (int i = 0; i < 18; i++) begin
            d.push_back(8'h10 + 8'(i));
            e[(12 + i) % 16] = 8'h10 + 8'(i);
        end
        wseq(8'h9C, d, na);
        chk(na, 8'h14);
        wait_idle();
        rseq(8'h90, 16);
        foreach (e[i])
            chk(q[i], e[i]);
        $display("page write done");
    endtask

    task automatic t_guard();
        wseq(8'h86, '{8'h00, 8'h11}, na);
        chk({na[6:0], latch}, 8'h06);
        wseq(8'h86, '{8'h80}, na);
        wp_n = 1'b0;
        wseq(8'hA0, '{8'h33}, na);
        chk(na, 8'h02);
        wseq(8'h86, '{8'h00}, na);
        chk({na[6:0], latch}, 8'h06);
        wp_n = 1'b1;
        $display("guards done");
    endtask

    // reset for two clocks, then the scenarios
    initial begin
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_addr();
        t_latch();
        t_page();
        t_guard();
        finish_test();
    end
endmodule

`default_nettype wire
